// [hdl/rti_pkg.sv]
package rti_pkg;

	// Device addresses on the two-wire bus; bit 0 selects the direction
	localparam logic [7:0] ADDR_WRITE = 8'ha2;
	localparam logic [7:0] ADDR_READ = 8'ha3;
	localparam int DIR_BIT = 0;

	// Byte framing
	localparam int BYTE_W = 8;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam int WADDR_W = 4;
	localparam int WADDR_MSB = 3;

	// Interface watchdog: figure in seconds, converted to cycles of clk
	localparam int CLK_HZ = 20000000;
	localparam int WD_TIME_S = 1;
	localparam int WD_CYCLES = CLK_HZ * WD_TIME_S;

	// Serial engine states
	typedef enum logic [2:0] {
		RTI_IDLE,
		RTI_ADDR,
		RTI_WADDR,
		RTI_WDATA,
		RTI_ACK,
		RTI_TX,
		RTI_TXACK
	} rti_state_t;

endpackage

// [hdl/rti_sync.sv]
`timescale 1ns/10ps

// Two-flop synchroniser; the first stage feeds only the second
module rti_sync #(
	parameter int W = 1
) (
	// Destination clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule

// [hdl/rti_top.sv]
`timescale 1ns/10ps

// Overview of operation
// - One bit per clock pulse; data stable high
// - Idle bus has both lines high
// - Start detected at any time except while the watchdog clears the interface
// - Stop detected and ends transfer
// - Unlimited bytes, eight bits plus acknowledge
// - Acknowledge every byte received when addressed
// - Acknowledger holds data low through pulse
// - Release data line after missing acknowledge
// - First byte after start is address
// - Slave only; clock input, data two-way
// - Answer A3h read, A2h write
// - Word address four bits, upper ignored
// - Freeze time counting during access
// - Watchdog clears hung interface, counting resumes
// - Expiry loses one second, uncompensated
// - Watchdog fires between one and two seconds
module rti_top
	import rti_pkg::*;
#(
	parameter int unsigned WD_CYCLES = rti_pkg::WD_CYCLES
) (
	// System clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Bus sampling clock
	input wire logic link_clk,
	// Two-wire bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	// Register access toward the time core
	output logic [rti_pkg::WADDR_W-1:0] reg_addr,
	output logic [rti_pkg::BYTE_W-1:0] reg_wdata,
	output logic reg_we,
	output logic reg_re,
	input wire logic [rti_pkg::BYTE_W-1:0] reg_rdata,
	// Time core control
	output logic freeze,
	output logic wd_expired
);
	import rti_pkg::*;

	// Link domain
	logic scl_n_s, sda_n_s, scl_s, sda_s, scl_p_q, sda_p_q, wd_s, rdack_s, rdack_p_q;
	rti_state_t st_q, st_d, nxt_q, nxt_d;
	logic [3:0] cnt_q, cnt_d;
	logic [BYTE_W-1:0] sh_q, sh_d, wr_data_q, wr_data_d, rd_byte_q;
	logic [WADDR_W-1:0] waddr_q, waddr_d, wr_addr_q, wr_addr_d, rd_addr_q, rd_addr_d;
	logic act_q, act_d, oe_n_q, oe_n_d, ackok_q, ackok_d;
	logic wr_tgl_q, wr_tgl_d, rd_tgl_q, rd_tgl_d, sda_o_q;

	// System domain
	logic act_s, wr_tgl_s, rd_tgl_s, wr_seen_q, rd_seen_q, rdack_tgl_q;
	logic [WADDR_W-1:0] reg_addr_q;
	logic [BYTE_W-1:0] reg_wdata_q, rdd_q;
	logic reg_we_q, reg_re_q, wd_fire, wd_fired_q, freeze_q, wd_expired_q;

	// Inverted through the synchroniser so its cleared state reads as an idle bus
	rti_sync #(.W(2)) u_pin_sync (
		.clk(link_clk),
		.nrst(nrst),
		.d({~scl_i, ~sda_i}),
		.q({scl_n_s, sda_n_s})
	);
	assign scl_s = !scl_n_s;
	assign sda_s = !sda_n_s;

	rti_sync #(.W(2)) u_to_link (
		.clk(link_clk),
		.nrst(nrst),
		.d({wd_fired_q, rdack_tgl_q}),
		.q({wd_s, rdack_s})
	);

	rti_sync #(.W(3)) u_to_sys (
		.clk(clk),
		.nrst(nrst),
		.d({act_q, wr_tgl_q, rd_tgl_q}),
		.q({act_s, wr_tgl_s, rd_tgl_s})
	);

	// Bus events decoded from the synchronised lines
	logic scl_rise, scl_fall, start_cond, stop_cond, addr_hit, byte_done, rdack_new;

	assign scl_rise = scl_s && !scl_p_q;
	assign scl_fall = !scl_s && scl_p_q;
	assign start_cond = scl_s && scl_p_q && sda_p_q && !sda_s;
	assign stop_cond = scl_s && scl_p_q && !sda_p_q && sda_s;
	assign addr_hit = (sh_q == ADDR_WRITE) || (sh_q == ADDR_READ);
	assign byte_done = scl_fall && (cnt_q == BYTE_BITS);
	assign rdack_new = rdack_s ^ rdack_p_q;

	always_comb begin
		st_d = st_q;
		nxt_d = nxt_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		waddr_d = waddr_q;
		act_d = act_q;
		oe_n_d = oe_n_q;
		ackok_d = ackok_q;
		wr_addr_d = wr_addr_q;
		wr_data_d = wr_data_q;
		wr_tgl_d = wr_tgl_q;
		rd_addr_d = rd_addr_q;
		rd_tgl_d = rd_tgl_q;
		if (wd_s) begin
			// Watchdog clears the interface until the next start
			st_d = RTI_IDLE;
			oe_n_d = 1'b1;
			act_d = 1'b0;
		end else if (start_cond) begin
			// A repeated start keeps the access open; the address decides
			st_d = RTI_ADDR;
			cnt_d = 4'h0;
			oe_n_d = 1'b1;
		end else if (stop_cond) begin
			st_d = RTI_IDLE;
			oe_n_d = 1'b1;
			act_d = 1'b0;
		end else begin
			case (st_q)
				RTI_ADDR, RTI_WADDR, RTI_WDATA: begin
					if (scl_rise) begin
						sh_d = {sh_q[BYTE_W-2:0], sda_s};
						cnt_d = cnt_q + 4'h1;
					end else if (byte_done) begin
						cnt_d = 4'h0;
						st_d = RTI_ACK;
						oe_n_d = 1'b0;
						if (st_q == RTI_ADDR) begin
							if (addr_hit) begin
								act_d = 1'b1;
								if (sh_q[DIR_BIT]) begin
									nxt_d = RTI_TX;
									rd_addr_d = waddr_q;
									rd_tgl_d = !rd_tgl_q;
								end else begin
									nxt_d = RTI_WADDR;
								end
							end else begin
								st_d = RTI_IDLE;
								oe_n_d = 1'b1;
								act_d = 1'b0;
							end
						end else if (st_q == RTI_WADDR) begin
							waddr_d = sh_q[WADDR_MSB:0];
							nxt_d = RTI_WDATA;
						end else begin
							wr_addr_d = waddr_q;
							wr_data_d = sh_q;
							wr_tgl_d = !wr_tgl_q;
							waddr_d = waddr_q + 4'h1;
							nxt_d = RTI_WDATA;
						end
					end
				end
				RTI_ACK: begin
					// Low is held until the falling edge ending the pulse
					if (scl_fall) begin
						st_d = nxt_q;
						if (nxt_q == RTI_TX) begin
							oe_n_d = rd_byte_q[BYTE_W-1];
							sh_d = {rd_byte_q[BYTE_W-2:0], 1'b0};
						end else begin
							oe_n_d = 1'b1;
						end
					end
				end
				RTI_TX: begin
					if (scl_rise) begin
						cnt_d = cnt_q + 4'h1;
					end else if (byte_done) begin
						cnt_d = 4'h0;
						oe_n_d = 1'b1;
						st_d = RTI_TXACK;
						waddr_d = waddr_q + 4'h1;
						rd_addr_d = waddr_q + 4'h1;
						rd_tgl_d = !rd_tgl_q;
					end else if (scl_fall) begin
						// Change data only while the clock is low
						oe_n_d = sh_q[BYTE_W-1];
						sh_d = {sh_q[BYTE_W-2:0], 1'b0};
					end
				end
				RTI_TXACK: begin
					if (scl_rise) begin
						ackok_d = !sda_s;
					end else if (scl_fall) begin
						if (ackok_q) begin
							st_d = RTI_TX;
							oe_n_d = rd_byte_q[BYTE_W-1];
							sh_d = {rd_byte_q[BYTE_W-2:0], 1'b0};
						end else begin
							// Line stays released so the master can stop
							st_d = RTI_IDLE;
							oe_n_d = 1'b1;
						end
					end
				end
				default: begin
					oe_n_d = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			st_q <= RTI_IDLE;
			nxt_q <= RTI_IDLE;
			cnt_q <= 4'h0;
			sh_q <= '0;
			waddr_q <= '0;
			act_q <= 1'b0;
			oe_n_q <= 1'b1;
			ackok_q <= 1'b0;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
			st_q <= st_d;
			nxt_q <= nxt_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			waddr_q <= waddr_d;
			act_q <= act_d;
			oe_n_q <= oe_n_d;
			ackok_q <= ackok_d;
		end
	end

	// Handshake words: data is held stable while its toggle crosses
	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			wr_addr_q <= '0;
			wr_data_q <= '0;
			wr_tgl_q <= 1'b0;
			rd_addr_q <= '0;
			rd_tgl_q <= 1'b0;
			rdack_p_q <= 1'b0;
			rd_byte_q <= '0;
			sda_o_q <= 1'b0;
		end else begin
			wr_addr_q <= wr_addr_d;
			wr_data_q <= wr_data_d;
			wr_tgl_q <= wr_tgl_d;
			rd_addr_q <= rd_addr_d;
			rd_tgl_q <= rd_tgl_d;
			rdack_p_q <= rdack_s;
			if (rdack_new) begin
				rd_byte_q <= rdd_q;
			end
			sda_o_q <= 1'b0;
		end
	end

	// System side
	logic wr_new, rd_new;

	assign wr_new = wr_tgl_s ^ wr_seen_q;
	assign rd_new = rd_tgl_s ^ rd_seen_q;

	// Read prefetch returns within a few cycles, well inside one bus bit
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_seen_q <= 1'b0;
			rd_seen_q <= 1'b0;
			reg_addr_q <= '0;
			reg_wdata_q <= '0;
			reg_we_q <= 1'b0;
			reg_re_q <= 1'b0;
			rdd_q <= '0;
			rdack_tgl_q <= 1'b0;
		end else begin
			wr_seen_q <= wr_tgl_s;
			rd_seen_q <= rd_new && !wr_new ? rd_tgl_s : rd_seen_q;
			reg_we_q <= wr_new;
			reg_re_q <= rd_new && !wr_new;
			if (wr_new) begin
				reg_addr_q <= wr_addr_q;
				reg_wdata_q <= wr_data_q;
			end else if (rd_new) begin
				reg_addr_q <= rd_addr_q;
			end
			if (reg_re_q) begin
				rdd_q <= reg_rdata;
				rdack_tgl_q <= !rdack_tgl_q;
			end
		end
	end

	rti_wdog #(.CYCLES(WD_CYCLES)) u_wdog (
		.clk(clk),
		.nrst(nrst),
		.run(act_s && !wd_fired_q),
		.fire(wd_fire)
	);

	// Expiry held until the link side drops its access level
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wd_fired_q <= 1'b0;
			freeze_q <= 1'b0;
			wd_expired_q <= 1'b0;
		end else begin
			wd_fired_q <= wd_fire || (wd_fired_q && act_s);
			freeze_q <= act_s && !wd_fired_q && !wd_fire;
			// The lost second is reported, not made up
			wd_expired_q <= wd_fire;
		end
	end

	assign sda_o = sda_o_q;
	assign sda_oe_n = oe_n_q;
	assign reg_addr = reg_addr_q;
	assign reg_wdata = reg_wdata_q;
	assign reg_we = reg_we_q;
	assign reg_re = reg_re_q;
	assign freeze = freeze_q;
	assign wd_expired = wd_expired_q;

endmodule

// [hdl/rti_wdog.sv]
`timescale 1ns/10ps

// Counts while run is high and pulses fire once, CYCLES-1 cycles after run rises
module rti_wdog #(
	parameter int unsigned CYCLES = 20000000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Control
	input wire logic run,
	output logic fire
);

	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);
	localparam logic [W-1:0] ONE = W'(1);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic hit;

	// Saturates at LAST so the pulse cannot repeat within one access
	assign hit = (cnt_q == LAST);
	assign cnt_d = !run ? '0 : (hit ? cnt_q : cnt_q + ONE);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
			fire <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			fire <= run && (cnt_d == LAST) && !hit;
		end
	end

endmodule

// [tb/rtc_i2c_slave_with_interface_watchdog_tb_top.sv]
`timescale 1ns/10ps

module rtc_i2c_slave_with_interface_watchdog_tb_top;
	import rti_pkg::*;
	localparam int unsigned WD = 4000;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic nrst = 1'b0;
	logic scl, sda_m, sda_o, sda_oe_n, reg_we, reg_re, freeze, wd_expired, ack;
	logic [WADDR_W-1:0] reg_addr;
	logic [BYTE_W-1:0] reg_wdata;
	logic [BYTE_W-1:0] reg_rdata = 8'h00;
	logic [7:0] rnd = 8'h03;
	logic [7:0] rx;
	logic [11:0] wq[$];
	int miscompares = 0;
	int compares = 0;
	int cyc = 0;
	// Pull-up wire
	wire sda = sda_m & (sda_oe_n | sda_o);
	initial forever #25 clk = ~clk;
	initial begin
		#7;
		forever #32 link_clk = ~link_clk;
	end
	rti_top #(.WD_CYCLES(WD)) i_rti_top (.clk, .nrst, .link_clk, .scl_i(scl), .sda_i(sda),
		.sda_o, .sda_oe_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .freeze,
		.wd_expired);
	rti_master i_rti_master (.clk, .scl, .sda_m, .sda);
	function automatic logic [7:0] rd_val(input logic [3:0] a);
		return {~a, a};
	endfunction
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(input string what, input logic [7:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(negedge clk) reg_rdata <= rd_val(reg_addr);
	// Ceiling is about three times the expected run
	// Outputs are taken mid-cycle, where they have settled
	always @(negedge clk) begin
		cyc++;
		if (reg_we) wq.push_back({reg_addr, reg_wdata});
		if (cyc == 60000) begin
			miscompares++;
			report_and_stop();
		end
	end
	initial begin
		logic [3:0] wa;
		logic [7:0] d[3];
		int n;
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		repeat (10) @(negedge clk);
		// First pass wraps the word address past 15
		for (int k = 0; k < 2; k++) begin
			rnd = lfsr(rnd);
			wa = k ? rnd[3:0] : 4'he;
			i_rti_master.start();
			i_rti_master.xfer(ADDR_WRITE, 1'b1, rx, ack);
			check("addr ack", ack, 1'b0);
			i_rti_master.xfer({rnd[7:4], wa}, 1'b1, rx, ack);
			check("waddr ack", ack, 1'b0);
			for (int i = 0; i < 3; i++) begin
				rnd = lfsr(rnd);
				d[i] = rnd;
				i_rti_master.xfer(rnd, 1'b1, rx, ack);
				check("data ack", ack, 1'b0);
			end
			check("frozen", freeze, 1'b1);
			i_rti_master.stop();
			repeat (20) @(negedge clk);
			check("thawed", freeze, 1'b0);
			check("writes", 8'(wq.size()), 8'h03);
			for (int i = 0; i < 3; i++) begin
				check("wr addr", wq[i][11:8], 4'(wa + i));
				check("wr data", wq[i][7:0], d[i]);
			end
			wq.delete();
		end
		$display("test done: write");
		rnd = lfsr(rnd);
		wa = rnd[3:0];
		i_rti_master.start();
		i_rti_master.xfer(ADDR_WRITE, 1'b1, rx, ack);
		i_rti_master.xfer({4'h0, wa}, 1'b1, rx, ack);
		i_rti_master.start();
		i_rti_master.xfer(ADDR_READ, 1'b1, rx, ack);
		check("read addr ack", ack, 1'b0);
		for (int i = 0; i < 3; i++) begin
			i_rti_master.xfer(8'hff, i == 2, rx, ack);
			check("read data", rx, rd_val(4'(wa + i)));
		end
		check("released", sda_oe_n, 1'b1);
		i_rti_master.stop();
		check("no writes", 8'(wq.size()), 8'h00);
		$display("test done: read");
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			if (rnd[7:1] == 7'h51) rnd = 8'ha0;
			i_rti_master.start();
			i_rti_master.xfer(rnd, 1'b1, rx, ack);
			check("foreign ack", ack, 1'b1);
			i_rti_master.xfer(8'h00, 1'b1, rx, ack);
			check("ignored", ack, 1'b1);
			check("not frozen", freeze, 1'b0);
			i_rti_master.stop();
		end
		$display("test done: foreign");
		// Hang after the address; the lost second is only reported
		i_rti_master.start();
		i_rti_master.xfer(ADDR_WRITE, 1'b1, rx, ack);
		n = 0;
		while (wd_expired !== 1'b1 && n < 3 * WD) begin
			@(negedge clk);
			n++;
		end
		check("wd window", n + 70 >= WD && n < 2 * WD, 1'b1);
		repeat (20) @(negedge clk);
		check("wd thaw", freeze, 1'b0);
		check("wd release", sda_oe_n, 1'b1);
		i_rti_master.xfer(8'h05, 1'b1, rx, ack);
		check("after wd", ack, 1'b1);
		i_rti_master.stop();
		$display("test done: watchdog");
		report_and_stop();
	end
endmodule

// [tb/rti_master.sv]
`timescale 1ns/10ps

// Bus master; SCL low lasts two quarters, above the read prefetch time
module rti_master (
	// Time base
	input wire logic clk,
	// Bus wires
	output logic scl,
	output logic sda_m,
	input wire logic sda
);
	localparam int Q = 15;
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic tick();
		repeat (Q) @(negedge clk);
	endtask
	task automatic start();
		sda_m = 1'b1;
		tick();
		scl = 1'b1;
		tick();
		sda_m = 1'b0;
		tick();
		scl = 1'b0;
		tick();
	endtask
	task automatic stop();
		sda_m = 1'b0;
		tick();
		scl = 1'b1;
		tick();
		sda_m = 1'b1;
		tick();
	endtask
	// Data only moves while SCL is low
	task automatic bit_io(input logic b, output logic s);
		sda_m = b;
		tick();
		scl = 1'b1;
		tick();
		s = sda;
		tick();
		scl = 1'b0;
		tick();
	endtask
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ack_in, ack);
	endtask
endmodule

// [tb/rti_top_assertions.sv]
`timescale 1ns/10ps

module rti_chk
	import rti_pkg::*;
#(
	parameter int unsigned WD_CYCLES = 4000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Watched outputs
	input wire logic sda_o,
	input wire logic sda_oe_n,
	input wire logic [rti_pkg::WADDR_W-1:0] reg_addr,
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic freeze,
	input wire logic wd_expired
);
	// Length of the current frozen stretch, to bound the watchdog
	int unsigned fz_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fz_q <= 0;
		end else begin
			fz_q <= freeze ? fz_q + 1 : 0;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_we_while_frozen: assert property (reg_we |-> freeze) else $error("write outside access");
	a_we_one_cycle: assert property (reg_we |=> !reg_we) else $error("write pulse too long");
	a_re_one_cycle: assert property (reg_re |=> !reg_re) else $error("read pulse too long");
	a_addr_hold: assert property ($changed(reg_addr) |-> reg_we || reg_re) else $error("addr moved");
	a_wd_window: assert property (wd_expired |-> fz_q + 8 >= WD_CYCLES && fz_q <= 2 * WD_CYCLES)
		else $error("watchdog out of window");
	a_freeze_bound: assert property (freeze |-> fz_q < 2 * WD_CYCLES) else $error("freeze too long");
	a_wd_thaws: assert property (wd_expired |=> !freeze) else $error("freeze kept after expiry");
	a_wd_releases: assert property (wd_expired |-> ##[0:20] sda_oe_n) else $error("bus kept");
	a_wd_one_pulse: assert property (wd_expired |=> !wd_expired) else $error("expiry pulse long");
	a_open_drain: assert property (!sda_o) else $error("data driven high");
endmodule

bind rti_top rti_chk #(.WD_CYCLES(WD_CYCLES)) i_rti_chk (.clk, .nrst, .sda_o, .sda_oe_n,
	.reg_addr, .reg_we, .reg_re, .freeze, .wd_expired);
